// [shared/smf_defines.svh]
// offsets, field positions, reset values and timing counts of the monitor
`ifndef SMF_DEFINES_SVH
`define SMF_DEFINES_SVH
`define SMF_CTRL_ADDR 8'hDF
`define SMF_CTRL_RESET 8'hDE
`define SMF_BIT_DCMP 6
`define SMF_BIT_FLAG 5
`define SMF_BIT_TRIP_HI 4
`define SMF_BIT_TRIP_LO 3
`define SMF_BIT_EN 0
`define SMF_TRIP_308 2'h1
`define SMF_TRIP_293 2'h2
`define SMF_CLK_HZ 200000000
`define SMF_HOLD_MS 250
`define SMF_HOLD_CYC ((`SMF_CLK_HZ / 1000) * `SMF_HOLD_MS)
`define SMF_GLITCH_NS 100
`define SMF_GLITCH_CYC ((`SMF_GLITCH_NS * 200 + 999) / 1000)
`endif

// [shared/smf_pkg.sv]
// types shared by the supply monitor flag logic
package smf_pkg;
    // special-function register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smf_sfr_req_s;
    // comparator pair as it arrives from the analog side
    typedef struct packed {
        logic digital_ok;
        logic analog_ok;
    } smf_cmp_s;
    typedef enum logic [2:0] {
        SMF_IDLE = 3'b001,
        SMF_LOW = 3'b010,
        SMF_HOLD = 3'b100
    } smf_state_e;
endpackage

// [hdl/smf_sync.sv]
// three-stage synchroniser with agreement filter for one comparator
`timescale 1ns/100ps
module smf_sync
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_async,
    output logic o_level
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic level_reg;
    logic level_next;

    // stage 2 and 3 must agree before the level moves
    always_comb
    begin
        sync_next = {sync_reg[1:0], i_async};
        level_next = level_reg;
        if (sync_reg[1] == sync_reg[2])
        begin
            level_next = sync_reg[2];
        end
    end

    // comparators idle high, so reset assumes a good supply
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            sync_reg <= 3'h7;
            level_reg <= 1'b1;
        end
        else
        begin
            sync_reg <= sync_next;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;
endmodule

// [hdl/smf_glitch.sv]
// stretch filter: low must persist a number of cycles before it counts
`timescale 1ns/100ps
`include "smf_defines.svh"
module smf_glitch
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_level,
    output logic o_low
);
    localparam int unsigned CW = 8;
    localparam logic [CW-1:0] LIMIT = CW'(`SMF_GLITCH_CYC);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic low_reg;
    logic low_next;

    // lows shorter than the limit are dropped; any high restarts the count
    always_comb
    begin
        cnt_next = '0;
        low_next = 1'b0;
        if (!i_level)
        begin
            if (cnt_reg >= LIMIT)
            begin
                cnt_next = cnt_reg;
                low_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cnt_reg <= '0;
            low_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            low_reg <= low_next;
        end
    end

    assign o_low = low_reg;
endmodule

// [hdl/smf_monitor.sv]
// supply monitor control register, low-supply flag and hold-off counter
//
// How it works
// - trip_select picks 3.08 V (01) or 2.93 V (10) for the comparator.
// - the flag goes high whenever either filtered comparator is low while bit 0 is 1.
// - once both comparators are high again a 250 ms counter runs.
// - when that counter expires the flag clears by itself.
// - software may write the flag but cannot clear it while low.
// - bit 6 reads the live digital comparator and ignores writes.
// - bit 6 reads 1 above the trip point and 0 below it.
// - the interrupt request leaves only when the core enable is set.
// - short lows on the comparators are filtered and never set it.
// - bits 4 and 3 hold the two-bit digital trip select field.
// - the monitor acts only while enable bit 0 is 1.
`timescale 1ns/100ps
`include "smf_defines.svh"
module smf_monitor
#(
    parameter int unsigned HOLD_CYC = `SMF_HOLD_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire smf_pkg::smf_sfr_req_s i_sfr,
    input wire smf_pkg::smf_cmp_s i_cmp,
    input wire logic i_irq_enable,
    output logic [7:0] o_rdata,
    output logic o_irq,
    output logic [1:0] o_trip_select,
    output logic o_monitor_enable
);
    import smf_pkg::*;

    localparam int unsigned HW = 26;

    logic dig_level;
    logic ana_level;
    logic dig_low;
    logic ana_low;
    logic any_low;
    logic sel_wr;
    logic sel_rd;

    logic [1:0] trip_reg;
    logic [1:0] trip_next;
    logic en_reg;
    logic en_next;
    logic flag_reg;
    logic flag_next;
    logic [HW-1:0] hold_reg;
    logic [HW-1:0] hold_next;
    smf_state_e state_reg;
    smf_state_e state_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_reg;
    logic irq_next;

    // comparators arrive from the analog domain, so synchronise first
    smf_sync u_sync_dig
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_async(i_cmp.digital_ok),
        .o_level(dig_level)
    );

    smf_sync u_sync_ana
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_async(i_cmp.analog_ok),
        .o_level(ana_level)
    );

    // glitch filters sit behind the synchronisers
    smf_glitch u_glitch_dig
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_level(dig_level),
        .o_low(dig_low)
    );

    smf_glitch u_glitch_ana
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_level(ana_level),
        .o_low(ana_low)
    );

    // a disabled monitor sees no lows at all
    assign any_low = en_reg & (dig_low | ana_low);

    // only the control register answers; any other address is ignored,
    // so a stray access elsewhere can never clear the flag by accident
    always_comb
    begin
        sel_wr = 1'b0;
        sel_rd = 1'b0;
        if (i_sfr.addr == `SMF_CTRL_ADDR)
        begin
            sel_wr = i_sfr.wr;
            sel_rd = i_sfr.rd;
        end
        else
        begin
            sel_wr = 1'b0;
            sel_rd = 1'b0;
        end
    end

    // writable control fields
    always_comb
    begin
        trip_next = trip_reg;
        en_next = en_reg;
        if (sel_wr)
        begin
            trip_next = i_sfr.wdata[`SMF_BIT_TRIP_HI:`SMF_BIT_TRIP_LO];
            en_next = i_sfr.wdata[`SMF_BIT_EN];
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            trip_reg <= 2'(`SMF_CTRL_RESET >> `SMF_BIT_TRIP_LO);
            en_reg <= 1'(`SMF_CTRL_RESET >> `SMF_BIT_EN);
        end
        else
        begin
            trip_reg <= trip_next;
            en_reg <= en_next;
        end
    end

    // flag and hold-off sequencing; hardware set beats a software clear
    always_comb
    begin
        state_next = state_reg;
        hold_next = hold_reg;
        flag_next = flag_reg;
        if (sel_wr)
        begin
            // a clear is refused while any comparator is low
            if (i_sfr.wdata[`SMF_BIT_FLAG] || !any_low)
            begin
                flag_next = i_sfr.wdata[`SMF_BIT_FLAG];
            end
        end
        case (state_reg)
            SMF_IDLE:
            begin
                hold_next = '0;
                if (any_low)
                begin
                    state_next = SMF_LOW;
                end
            end
            SMF_LOW:
            begin
                hold_next = '0;
                if (!any_low)
                begin
                    state_next = SMF_HOLD;
                end
            end
            SMF_HOLD:
            begin
                if (any_low)
                begin
                    state_next = SMF_LOW;
                    hold_next = '0;
                end
                else if (hold_reg >= HW'(HOLD_CYC - 1))
                begin
                    state_next = SMF_IDLE;
                    hold_next = '0;
                    flag_next = 1'b0;
                end
                else
                begin
                    hold_next = hold_reg + HW'(1);
                end
            end
            default:
            begin
                state_next = SMF_IDLE;
                hold_next = '0;
            end
        endcase
        if (any_low)
        begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            state_reg <= SMF_IDLE;
            hold_reg <= '0;
            flag_reg <= 1'(`SMF_CTRL_RESET >> `SMF_BIT_FLAG);
        end
        else
        begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            flag_reg <= flag_next;
        end
    end

    // registered read data and gated interrupt request
    always_comb
    begin
        rdata_next = rdata_reg;
        if (sel_rd)
        begin
            rdata_next = 8'h00;
            rdata_next[`SMF_BIT_DCMP] = dig_level;
            rdata_next[`SMF_BIT_FLAG] = flag_reg;
            rdata_next[`SMF_BIT_TRIP_HI:`SMF_BIT_TRIP_LO] = trip_reg;
            rdata_next[`SMF_BIT_EN] = en_reg;
        end
        irq_next = flag_reg & i_irq_enable;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    // trip select drives the analog threshold mux directly
    assign o_rdata = rdata_reg;
    assign o_irq = irq_reg;
    assign o_trip_select = trip_reg;
    assign o_monitor_enable = en_reg;
endmodule

// [verif/smf_cmp_model.sv]
// comparator pair model: supply level against the selected trip point
`timescale 1ns/100ps
module smf_cmp_model
(
    input wire logic [11:0] i_supply_mv,
    input wire logic [1:0] i_trip_select,
    input wire logic i_analog_ok,
    output wire smf_pkg::smf_cmp_s o_cmp
);
    import smf_pkg::*;
    logic [11:0] trip_mv;
    // reserved codes fall back to the higher point, which errs safe
    assign trip_mv = (i_trip_select == 2'h2) ? 12'hB72 : 12'hC08;
    // skew keeps comparator edges away from the sampling edge
    assign #1.7 o_cmp = {i_supply_mv > trip_mv, i_analog_ok};
endmodule

// [verif/smf_monitor_chk.sv]
// port assertions for the supply monitor
`timescale 1ns/100ps
module smf_monitor_chk
#(
    parameter int unsigned HOLD_CYC = 50
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire smf_pkg::smf_sfr_req_s i_sfr,
    input wire smf_pkg::smf_cmp_s i_cmp,
    input wire logic i_irq_enable,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq,
    input wire logic [1:0] o_trip_select,
    input wire logic o_monitor_enable
);
    import smf_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    logic hit_wr, hit_rd, wr_d_reg;
    int unsigned low_cnt_reg, low_next, high_cnt_reg, high_next;
    assign hit_wr = i_sfr.wr && i_sfr.addr == 8'hDF;
    assign hit_rd = i_sfr.rd && i_sfr.addr == 8'hDF;
    // raw low and high run lengths; raw leads the filtered view
    always_comb
    begin
        low_next = 0;
        high_next = 0;
        if (o_monitor_enable && i_irq_enable && !(&i_cmp))
            low_next = (low_cnt_reg < 40) ? low_cnt_reg + 1 : 40;
        if (&i_cmp)
            high_next = high_cnt_reg + (high_cnt_reg < HOLD_CYC);
    end
    always_ff @(posedge i_clk_sys)
    begin
        low_cnt_reg <= i_srst ? 0 : low_next;
        high_cnt_reg <= i_srst ? 0 : high_next;
        wr_d_reg <= !i_srst && hit_wr;
    end
    a_irq_gated: assert property (o_irq |-> $past(i_irq_enable))
        else $error("irq raised without enable");
    a_trip_write: assert property (hit_wr |=>
        o_trip_select == $past(i_sfr.wdata[4:3]))
        else $error("trip select not written");
    a_enable_write: assert property (hit_wr |=>
        o_monitor_enable == $past(i_sfr.wdata[0]))
        else $error("enable not written");
    a_rdata_holds: assert property (!hit_rd |=> $stable(o_rdata))
        else $error("read data moved without read");
    a_reserved_zero: assert property (hit_rd |=>
        !o_rdata[7] && o_rdata[2:1] == 2'h0)
        else $error("reserved bits not zero");
    a_rdata_fields: assert property (hit_rd |=>
        {o_rdata[4:3], o_rdata[0]} == $past({o_trip_select, o_monitor_enable}))
        else $error("read fields wrong");
    a_low_sets: assert property (low_cnt_reg == 40 |-> o_irq)
        else $error("long low left flag clear");
    a_no_early: assert property (o_irq && i_irq_enable && !hit_wr
        && !wr_d_reg && high_cnt_reg < HOLD_CYC |=> o_irq)
        else $error("flag cleared before hold-off");
endmodule
bind smf_monitor smf_monitor_chk #(.HOLD_CYC(HOLD_CYC)) i_smf_monitor_chk (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sfr(i_sfr), .i_cmp(i_cmp),
    .i_irq_enable(i_irq_enable), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_trip_select(o_trip_select), .o_monitor_enable(o_monitor_enable));

// [verif/tb_smf_monitor.sv]
// self-checking bench for the supply monitor flag logic
`timescale 1ns/100ps
module tb_smf_monitor;
    import smf_pkg::*;
    localparam int HOLD = 50;
    logic i_clk_sys = 0, i_srst = 1, i_irq_enable = 0, ana_ok = 1, o_irq;
    logic [11:0] supply_mv = 12'hCE4; // 3300 mV
    smf_sfr_req_s i_sfr = '0;
    smf_cmp_s i_cmp;
    logic [7:0] o_rdata;
    logic [1:0] o_trip_select;
    logic o_monitor_enable;
    int fails = 0, n_tests = 0;
    always #2.5 i_clk_sys = ~i_clk_sys;
    smf_cmp_model i_smf_cmp_model (.i_supply_mv(supply_mv),
        .i_trip_select(o_trip_select), .i_analog_ok(ana_ok), .o_cmp(i_cmp));
    smf_monitor #(.HOLD_CYC(HOLD)) i_smf_monitor (.i_clk_sys(i_clk_sys),
        .i_srst(i_srst), .i_sfr(i_sfr), .i_cmp(i_cmp),
        .i_irq_enable(i_irq_enable), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_trip_select(o_trip_select), .o_monitor_enable(o_monitor_enable));
    task tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // idle cycle after each access so strobes never toggle in one step
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_sfr = '{w, !w, a, d};
        tick(1);
        i_sfr = '0;
        tick(1);
    endtask
    task rd(input logic [7:0] exp);
        bus(0, 8'hDF, 8'h00);
        chk(o_rdata, exp);
    endtask
    task t_reset;
        bus(1, 8'hDE, 8'h01);
        rd(8'h58);
    endtask
    task t_regs;
        bus(1, 8'hDF, 8'h0F);
        rd(8'h49);
        bus(1, 8'hDF, 8'hD1);
        rd(8'h51);
    endtask
    task t_glitch;
        i_irq_enable = 1;
        supply_mv = 12'hAF0; // 2800 mV
        tick(6);
        supply_mv = 12'hCE4;
        tick(40);
        rd(8'h51);
    endtask
    task t_trip;
        supply_mv = 12'hBB8; // 3000 mV, between the two points
        tick(40);
        rd(8'h51);
        bus(1, 8'hDF, 8'h09);
        tick(40);
        chk({7'h00, o_irq}, 8'h01);
        rd(8'h29);
        bus(1, 8'hDF, 8'h09);
        rd(8'h29);
        i_irq_enable = 0;
        tick(2);
        chk({7'h00, o_irq}, 8'h00);
        i_irq_enable = 1;
        tick(2);
        chk({7'h00, o_irq}, 8'h01);
    endtask
    task t_holdoff;
        supply_mv = 12'hCE4;
        tick(20);
        ana_ok = 0;
        tick(40);
        ana_ok = 1;
        tick(HOLD - 10);
        chk({7'h00, o_irq}, 8'h01);
        for (int i = 0; i < 30 && o_irq; i++)
            tick(1);
        chk({7'h00, o_irq}, 8'h00);
    endtask
    task t_disable;
        bus(1, 8'hDF, 8'h10);
        supply_mv = 12'hAF0;
        tick(40);
        rd(8'h10);
        chk({7'h00, o_irq}, 8'h00);
        supply_mv = 12'hCE4;
    endtask
    task close_out;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial
    begin
        #20000;
        fails++;
        close_out;
    end
    initial
    begin
        tick(8);
        i_srst = 0;
        t_reset;
        t_regs;
        t_glitch;
        t_trip;
        t_holdoff;
        t_disable;
        close_out;
    end
endmodule
